// ---- hdl/sensor_ctrl.sv ----
`timescale 1ns/100ps
// Behaviour
// - rate field resets to power-down code
// - power-down keeps config, output data changes only on one-shot
// - register access stays alive in power-down
// - nonzero rate acquires pressure/temperature pairs periodically
// - one-shot plus seven continuous rates
// - one-shot trigger accepted only in power-down
// - one-shot completion clears trigger, back to idle
// - extra filter enable smooths continuous pressure
// - bandwidth OUTPUT_RATE_SELECT/2, OUTPUT_RATE_SELECT/9 or OUTPUT_RATE_SELECT/20
// - 100/200Hz force low-noise off
// - hold freezes outputs until high pressure byte read
// - wire-count bit selects 4-wire or 3-wire
// - two-wire enabled at reset, bit disables
// - I3C disable bit switches I3C off
// - interrupt pad driven under I3C when enabled
// - data-line pull-up control
// - serial-out pull-up control
// - interrupt pad pull-down disable
module sensor_ctrl #(
  parameter logic [7:0] DEVICE_ID = 8'h5A, // identity value, arbitrary
  parameter int unsigned TICKS_PER_SEC = sensor_ctrl_pkg::CLK_HZ // shorten for sim
) (
  input wire logic clk_i, // system clock
  input wire logic sys_rst_i, // sync reset, active high
  input wire logic link_clk_i, // register access clock
  input wire logic acc_req_i, // access request, link domain
  input wire logic acc_we_i, // 1 write, 0 read
  input wire logic [sensor_ctrl_pkg::ADDR_W-1:0] acc_addr_i, // register address
  input wire logic [7:0] acc_wdata_i, // write data
  output logic acc_busy_o, // access in flight
  output logic acc_done_o, // access finished pulse
  output logic [7:0] acc_rdata_o, // read data
  output logic conv_start_o, // start one conversion pulse
  input wire logic conv_done_i, // conversion result valid
  input wire logic [23:0] press_raw_i, // raw pressure
  input wire logic [15:0] temp_raw_i, // raw temperature
  input wire logic i3c_mode_i, // bus running I3C, async pin
  output logic i2c_enable_o, // two-wire interface on
  output logic i3c_enable_o, // I3C protocol on
  output logic spi_three_wire_o, // 1 three-wire, 0 four-wire
  output logic sda_pullup_o, // data-line pull-up connected
  output logic sdo_pullup_o, // serial-out pull-up connected
  output logic int_pulldown_o, // interrupt pad pull-down connected
  output logic int_pad_oe_o, // interrupt pad output enable
  output logic lpf_enable_o, // extra filter active
  output logic [1:0] bw_sel_o, // bandwidth code
  output logic low_noise_o // low-noise mode active
);
  import sensor_ctrl_pkg::*;

  // rate period in system cycles per rate code
  function automatic logic [31:0] rate_period(input logic [2:0] code);
    case (code)
      3'h1: rate_period = 32'(TICKS_PER_SEC / 1);
      3'h2: rate_period = 32'(TICKS_PER_SEC / 10);
      3'h3: rate_period = 32'(TICKS_PER_SEC / 25);
      3'h4: rate_period = 32'(TICKS_PER_SEC / 50);
      3'h5: rate_period = 32'(TICKS_PER_SEC / 75);
      3'h6: rate_period = 32'(TICKS_PER_SEC / 100);
      3'h7: rate_period = 32'(TICKS_PER_SEC / 200);
      default: rate_period = 32'h0000_0001;
    endcase
  endfunction : rate_period

  // link domain state
  logic lrst_m_r, lrst_r; // link reset synchroniser
  logic l_req_tgl_r, l_req_tgl_nxt; // request toggle to system side
  logic l_ack_m_r, l_ack_s_r, l_ack_seen_r; // ack toggle sync
  logic l_busy_r, l_busy_nxt;
  logic l_done_r, l_done_nxt;
  logic [7:0] l_rdata_r, l_rdata_nxt;
  logic [6:0] l_addr_r, l_addr_nxt; // held stable while busy
  logic l_we_r, l_we_nxt;
  logic [7:0] l_wdata_r, l_wdata_nxt;

  // system domain state
  logic s_req_m_r, s_req_s_r, s_req_seen_r; // request toggle sync
  logic s_ack_tgl_r, s_ack_tgl_nxt;
  logic [7:0] s_rdata_r, s_rdata_nxt; // held until next access
  logic i3c_m_r, i3c_s_r; // pin synchroniser
  logic [7:0] if_ctrl_r, if_ctrl_nxt;
  logic [7:0] acq_ctrl_r, acq_ctrl_nxt;
  logic oneshot_r, oneshot_nxt;
  logic lownoise_r, lownoise_nxt;
  acq_state_t state_r, state_nxt;
  logic [31:0] rate_cnt_r, rate_cnt_nxt;
  logic start_r, start_nxt;
  logic [23:0] samp_p_r, samp_p_nxt; // newest sample
  logic [15:0] samp_t_r, samp_t_nxt;
  logic [23:0] filt_r, filt_nxt; // filtered pressure
  logic filt_ok_r, filt_ok_nxt; // filter seeded
  logic new_r, new_nxt; // sample waiting for outputs
  logic lock_r, lock_nxt; // outputs frozen mid-read
  logic [23:0] out_p_r, out_p_nxt;
  logic [15:0] out_t_r, out_t_nxt;

  // decoded fields
  logic [2:0] output_rate_select;
  logic hold_en, lp_en, lp_cfg, acc_stb, is_out_addr;
  logic copy_ok; // sample moves to outputs this cycle
  logic signed [24:0] diff;
  assign output_rate_select = acq_ctrl_r[ACQ_ODR_LSB +: 3];
  assign hold_en = acq_ctrl_r[ACQ_HOLD_BIT];
  assign lp_en = acq_ctrl_r[ACQ_LPEN_BIT];
  assign lp_cfg = acq_ctrl_r[ACQ_LPCFG_BIT];
  assign acc_stb = s_req_s_r ^ s_req_seen_r;
  assign is_out_addr = (l_addr_r >= ADDR_PRESS_XL) && (l_addr_r <= ADDR_TEMP_H);
  assign diff = $signed({1'b0, press_raw_i}) - $signed({1'b0, filt_r});

  // link side: launch request, wait for toggled ack
  always_comb begin
    l_req_tgl_nxt = l_req_tgl_r;
    l_busy_nxt = l_busy_r;
    l_done_nxt = 1'b0;
    l_rdata_nxt = l_rdata_r;
    l_addr_nxt = l_addr_r;
    l_we_nxt = l_we_r;
    l_wdata_nxt = l_wdata_r;
    if (!l_busy_r && acc_req_i) begin // capture and launch
      l_addr_nxt = acc_addr_i;
      l_we_nxt = acc_we_i;
      l_wdata_nxt = acc_wdata_i;
      l_req_tgl_nxt = ~l_req_tgl_r;
      l_busy_nxt = 1'b1;
    end else if (l_busy_r && (l_ack_s_r != l_ack_seen_r)) begin // answer back
      l_rdata_nxt = s_rdata_r; // stable since ack toggled
      l_busy_nxt = 1'b0;
      l_done_nxt = 1'b1;
    end
  end

  // link side registers
  always_ff @(posedge link_clk_i) begin
    lrst_m_r <= sys_rst_i;
    lrst_r <= lrst_m_r;
    if (lrst_r) begin
      l_req_tgl_r <= 1'b0;
      l_ack_m_r <= 1'b0;
      l_ack_s_r <= 1'b0;
      l_ack_seen_r <= 1'b0;
      l_busy_r <= 1'b0;
      l_done_r <= 1'b0;
      l_rdata_r <= 8'h00;
      l_addr_r <= 7'h00;
      l_we_r <= 1'b0;
      l_wdata_r <= 8'h00;
    end else begin
      l_req_tgl_r <= l_req_tgl_nxt;
      l_ack_m_r <= s_ack_tgl_r;
      l_ack_s_r <= l_ack_m_r;
      l_ack_seen_r <= l_ack_s_r;
      l_busy_r <= l_busy_nxt;
      l_done_r <= l_done_nxt;
      l_rdata_r <= l_rdata_nxt;
      l_addr_r <= l_addr_nxt;
      l_we_r <= l_we_nxt;
      l_wdata_r <= l_wdata_nxt;
    end
  end

  // system side: registers, sequencer, output data
  always_comb begin
    s_ack_tgl_nxt = s_ack_tgl_r;
    s_rdata_nxt = s_rdata_r;
    if_ctrl_nxt = if_ctrl_r;
    acq_ctrl_nxt = acq_ctrl_r;
    oneshot_nxt = oneshot_r;
    lownoise_nxt = lownoise_r;
    state_nxt = state_r;
    rate_cnt_nxt = rate_cnt_r;
    start_nxt = 1'b0;
    samp_p_nxt = samp_p_r;
    samp_t_nxt = samp_t_r;
    filt_nxt = filt_r;
    filt_ok_nxt = filt_ok_r;
    lock_nxt = lock_r;
    out_p_nxt = out_p_r;
    out_t_nxt = out_t_r;
    // register access works in every mode
    if (acc_stb) begin
      s_ack_tgl_nxt = ~s_ack_tgl_r;
      if (l_we_r) begin
        s_rdata_nxt = 8'h00;
        case (l_addr_r)
          ADDR_IF_CTRL: if_ctrl_nxt = l_wdata_r & IF_CTRL_MASK;
          ADDR_ACQ_CTRL: acq_ctrl_nxt = l_wdata_r & ACQ_CTRL_MASK;
          ADDR_ACQ_CTRL2: begin
            lownoise_nxt = l_wdata_r[ACQ2_LOWNOISE_BIT];
            // trigger only from power-down
            if (l_wdata_r[ACQ2_ONESHOT_BIT] && (output_rate_select == ODR_OFF)) begin
              oneshot_nxt = 1'b1;
            end
          end
          default: ; // identity, output data and unmapped: ignored
        endcase
      end else begin
        case (l_addr_r)
          ADDR_IF_CTRL: s_rdata_nxt = if_ctrl_r;
          ADDR_IDENT: s_rdata_nxt = DEVICE_ID;
          ADDR_ACQ_CTRL: s_rdata_nxt = acq_ctrl_r;
          ADDR_ACQ_CTRL2: s_rdata_nxt = {6'h00, lownoise_r, oneshot_r};
          ADDR_PRESS_XL: s_rdata_nxt = out_p_r[7:0];
          ADDR_PRESS_L: s_rdata_nxt = out_p_r[15:8];
          ADDR_PRESS_H: s_rdata_nxt = out_p_r[23:16];
          ADDR_TEMP_L: s_rdata_nxt = out_t_r[7:0];
          ADDR_TEMP_H: s_rdata_nxt = out_t_r[15:8];
          default: s_rdata_nxt = 8'h00; // unmapped reads zero
        endcase
        // hold: any output read locks, high pressure byte unlocks
        if (is_out_addr && hold_en) begin
          lock_nxt = (l_addr_r != ADDR_PRESS_H);
        end
      end
    end
    if (!hold_en) begin
      lock_nxt = 1'b0; // continuous update
    end
    // rate timer, idle in power-down
    if (output_rate_select == ODR_OFF) begin
      rate_cnt_nxt = 32'h0000_0000;
      filt_ok_nxt = 1'b0;
    end else if (rate_cnt_r == 32'h0000_0000) begin
      rate_cnt_nxt = rate_period(output_rate_select) - 32'h0000_0001;
    end else begin
      rate_cnt_nxt = rate_cnt_r - 32'h0000_0001;
    end
    // conversion sequencer
    case (state_r)
      ACQ_IDLE: begin
        if (((output_rate_select != ODR_OFF) && (rate_cnt_r == 32'h0000_0000)) || oneshot_r) begin
          start_nxt = 1'b1;
          state_nxt = ACQ_CONV;
        end
      end
      ACQ_CONV: begin
        if (conv_done_i) begin
          state_nxt = ACQ_IDLE;
          samp_t_nxt = temp_raw_i;
          samp_p_nxt = press_raw_i;
          if ((output_rate_select != ODR_OFF) && lp_en) begin // filter in continuous only
            if (!filt_ok_r) begin
              filt_nxt = press_raw_i; // seed on first sample
            end else if (lp_cfg) begin
              filt_nxt = filt_r + 24'(diff >>> LPF_SHIFT_DIV20);
            end else begin
              filt_nxt = filt_r + 24'(diff >>> LPF_SHIFT_DIV9);
            end
            filt_ok_nxt = 1'b1;
            samp_p_nxt = filt_nxt;
          end
          oneshot_nxt = 1'b0; // self-clear, back to power-down
        end
      end
      default: state_nxt = ACQ_IDLE;
    endcase
    // move newest sample unless frozen now or by the read in flight
    copy_ok = new_r && !lock_r && !lock_nxt;
    if (copy_ok) begin
      out_p_nxt = samp_p_r;
      out_t_nxt = samp_t_r;
    end
    // arriving sample wins over the copy-clear
    new_nxt = (new_r && !copy_ok) || ((state_r == ACQ_CONV) && conv_done_i);
  end

  // system side registers
  always_ff @(posedge clk_i) begin
    i3c_m_r <= i3c_mode_i;
    i3c_s_r <= i3c_m_r;
    if (sys_rst_i) begin
      s_req_m_r <= 1'b0;
      s_req_s_r <= 1'b0;
      s_req_seen_r <= 1'b0;
      s_ack_tgl_r <= 1'b0;
      s_rdata_r <= 8'h00;
      if_ctrl_r <= IF_CTRL_RST; // both serial interfaces on
      acq_ctrl_r <= ACQ_CTRL_RST; // power-down
      oneshot_r <= ACQ2_RST[ACQ2_ONESHOT_BIT];
      lownoise_r <= ACQ2_RST[ACQ2_LOWNOISE_BIT];
      state_r <= ACQ_IDLE;
      rate_cnt_r <= 32'h0000_0000;
      start_r <= 1'b0;
      samp_p_r <= 24'h000000;
      samp_t_r <= 16'h0000;
      filt_r <= 24'h000000;
      filt_ok_r <= 1'b0;
      new_r <= 1'b0;
      lock_r <= 1'b0;
      out_p_r <= 24'h000000;
      out_t_r <= 16'h0000;
    end else begin
      s_req_m_r <= l_req_tgl_r;
      s_req_s_r <= s_req_m_r;
      s_req_seen_r <= s_req_s_r;
      s_ack_tgl_r <= s_ack_tgl_nxt;
      s_rdata_r <= s_rdata_nxt;
      if_ctrl_r <= if_ctrl_nxt;
      acq_ctrl_r <= acq_ctrl_nxt;
      oneshot_r <= oneshot_nxt;
      lownoise_r <= lownoise_nxt;
      state_r <= state_nxt;
      rate_cnt_r <= rate_cnt_nxt;
      start_r <= start_nxt;
      samp_p_r <= samp_p_nxt;
      samp_t_r <= samp_t_nxt;
      filt_r <= filt_nxt;
      filt_ok_r <= filt_ok_nxt;
      new_r <= new_nxt;
      lock_r <= lock_nxt;
      out_p_r <= out_p_nxt;
      out_t_r <= out_t_nxt;
    end
  end

  // registered pad and mode controls
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      i2c_enable_o <= 1'b1;
      i3c_enable_o <= 1'b1;
      spi_three_wire_o <= 1'b0;
      sda_pullup_o <= 1'b0;
      sdo_pullup_o <= 1'b0;
      int_pulldown_o <= 1'b1;
      int_pad_oe_o <= 1'b0;
      lpf_enable_o <= 1'b0;
      bw_sel_o <= BW_DIV2;
      low_noise_o <= 1'b0;
      conv_start_o <= 1'b0;
    end else begin
      i2c_enable_o <= ~if_ctrl_r[IF_I2C_OFF_BIT];
      i3c_enable_o <= ~if_ctrl_r[IF_I3C_OFF_BIT];
      spi_three_wire_o <= acq_ctrl_r[ACQ_SPI3_BIT];
      sda_pullup_o <= if_ctrl_r[IF_SDA_PU_BIT];
      sdo_pullup_o <= if_ctrl_r[IF_SDO_PU_BIT];
      int_pulldown_o <= ~if_ctrl_r[IF_PD_OFF_BIT];
      int_pad_oe_o <= ~i3c_s_r | if_ctrl_r[IF_INT_I3C_BIT];
      lpf_enable_o <= lp_en && (output_rate_select != ODR_OFF);
      bw_sel_o <= !lp_en ? BW_DIV2 : (lp_cfg ? BW_DIV20 : BW_DIV9);
      low_noise_o <= lownoise_r && (output_rate_select != ODR_100HZ) && (output_rate_select != ODR_200HZ);
      conv_start_o <= start_r;
    end
  end

  assign acc_busy_o = l_busy_r;
  assign acc_done_o = l_done_r;
  assign acc_rdata_o = l_rdata_r;
endmodule : sensor_ctrl

// ---- hdl/sensor_ctrl_pkg.sv ----
package sensor_ctrl_pkg;
  // register address space
  localparam int ADDR_W = 7;
  localparam logic [6:0] ADDR_IF_CTRL = 7'h0E;
  localparam logic [6:0] ADDR_IDENT = 7'h0F;
  localparam logic [6:0] ADDR_ACQ_CTRL = 7'h10;
  localparam logic [6:0] ADDR_ACQ_CTRL2 = 7'h11;
  localparam logic [6:0] ADDR_PRESS_XL = 7'h28;
  localparam logic [6:0] ADDR_PRESS_L = 7'h29;
  localparam logic [6:0] ADDR_PRESS_H = 7'h2A;
  localparam logic [6:0] ADDR_TEMP_L = 7'h2B;
  localparam logic [6:0] ADDR_TEMP_H = 7'h2C;
  // interface control fields
  localparam int IF_I2C_OFF_BIT = 0;
  localparam int IF_I3C_OFF_BIT = 1;
  localparam int IF_PD_OFF_BIT = 2;
  localparam int IF_SDO_PU_BIT = 3;
  localparam int IF_SDA_PU_BIT = 4;
  localparam int IF_INT_I3C_BIT = 7;
  localparam logic [7:0] IF_CTRL_MASK = 8'h9F;
  localparam logic [7:0] IF_CTRL_RST = 8'h00;
  // acquisition control fields
  localparam int ACQ_SPI3_BIT = 0;
  localparam int ACQ_HOLD_BIT = 1;
  localparam int ACQ_LPCFG_BIT = 2;
  localparam int ACQ_LPEN_BIT = 3;
  localparam int ACQ_ODR_LSB = 4;
  localparam logic [7:0] ACQ_CTRL_MASK = 8'h7F;
  localparam logic [7:0] ACQ_CTRL_RST = 8'h00;
  // second control register fields (one-shot, low noise)
  localparam int ACQ2_ONESHOT_BIT = 0;
  localparam int ACQ2_LOWNOISE_BIT = 1;
  localparam logic [7:0] ACQ2_RST = 8'h00;
  // output rate codes
  localparam logic [2:0] ODR_OFF = 3'h0;
  localparam logic [2:0] ODR_100HZ = 3'h6;
  localparam logic [2:0] ODR_200HZ = 3'h7;
  // bandwidth codes on bw_sel_o
  localparam logic [1:0] BW_DIV2 = 2'h0;
  localparam logic [1:0] BW_DIV9 = 2'h1;
  localparam logic [1:0] BW_DIV20 = 2'h2;
  // extra filter smoothing shifts
  localparam int LPF_SHIFT_DIV9 = 3;
  localparam int LPF_SHIFT_DIV20 = 4;
  // clock
  localparam int CLK_PERIOD_NS = 10;
  localparam int CLK_HZ = 1000000000 / CLK_PERIOD_NS;
  // acquisition sequencer states
  typedef enum logic [1:0] {
    ACQ_IDLE = 2'b01,
    ACQ_CONV = 2'b10
  } acq_state_t;
endpackage : sensor_ctrl_pkg

// ---- test/sensor_ctrl_props.sv ----
`timescale 1ns/100ps
module sensor_ctrl_props (
  input wire logic clk_i, // system clock
  input wire logic sys_rst_i, // sync reset
  input wire logic link_clk_i, // access clock
  input wire logic acc_req_i, // access request
  input wire logic acc_busy_o, // access in flight
  input wire logic acc_done_o, // access finished
  input wire logic conv_start_o, // conversion start
  input wire logic conv_done_i, // conversion done
  input wire logic i3c_mode_i, // bus in I3C use
  input wire logic i2c_enable_o, // two-wire on
  input wire logic i3c_enable_o, // I3C on
  input wire logic int_pulldown_o, // pad pull-down on
  input wire logic sda_pullup_o, // data-line pull-up
  input wire logic int_pad_oe_o, // pad output enable
  input wire logic [1:0] bw_sel_o // bandwidth code
);
  logic pend_r; // conversion outstanding
  logic pend_nxt; // next outstanding flag
  // set on start, cleared by result
  always_comb begin
    pend_nxt = pend_r;
    if (conv_start_o) begin
      pend_nxt = 1'b1;
    end else if (conv_done_i) begin
      pend_nxt = 1'b0;
    end
  end
  // register the flag
  always_ff @(posedge clk_i) begin
    pend_r <= sys_rst_i ? 1'b0 : pend_nxt;
  end
  // request taken while idle
  sequence acc_take;
    acc_req_i && !acc_busy_o;
  endsequence
  // busy for a few cycles then done
  sequence acc_answer;
    acc_busy_o [*2] ##[1:4] acc_done_o;
  endsequence
  rst_values_a: assert property (@(posedge clk_i) sys_rst_i [*2] |-> i2c_enable_o &&
    i3c_enable_o && int_pulldown_o && !sda_pullup_o) else $error("reset pin levels wrong");
  acc_ack_a: assert property (@(posedge link_clk_i) disable iff (sys_rst_i)
    acc_take |=> acc_answer) else $error("access not answered in time");
  done_pulse_a: assert property (@(posedge link_clk_i) disable iff (sys_rst_i)
    acc_done_o |=> !acc_done_o) else $error("done longer than one cycle");
  done_idle_a: assert property (@(posedge link_clk_i) disable iff (sys_rst_i)
    acc_done_o |-> !acc_busy_o) else $error("busy together with done");
  start_pulse_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(conv_start_o) |=> $fell(conv_start_o)) else $error("start pulse too long");
  start_order_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    conv_start_o |-> !pend_r) else $error("start before previous done");
  irq_oe_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!sys_rst_i && !i3c_mode_i) [*5] |-> int_pad_oe_o) else $error("pad not driven");
  bw_code_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    bw_sel_o != 2'h3) else $error("illegal bandwidth code");
endmodule : sensor_ctrl_props

// ---- test/frontend_model.sv ----
`timescale 1ns/100ps
module frontend_model (
  input wire logic clk_i, // system clock
  input wire logic start_i, // conversion request
  output logic done_o, // result valid pulse
  output logic [23:0] press_o, // pressure sample
  output logic [15:0] temp_o // temperature sample
);
  logic [7:0] k_r; // sample number
  logic [2:0] cnt_r; // conversion time left
  initial begin
    k_r = 8'h00;
    cnt_r = 3'h0;
    done_o = 1'b0;
    press_o = 24'h000000;
    temp_o = 16'h0000;
  end
  // data lines toggle outside the result cycle
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    press_o <= ~press_o;
    temp_o <= ~temp_o;
    if (start_i === 1'b1) begin
      k_r <= k_r + 8'h01;
      cnt_r <= 3'h3;
    end else if (cnt_r == 3'h1) begin
      done_o <= 1'b1;
      press_o <= {3{k_r}};
      temp_o <= {k_r, ~k_r};
      cnt_r <= 3'h0;
    end else if (cnt_r != 3'h0) begin
      cnt_r <= cnt_r - 3'h1;
    end
  end
endmodule : frontend_model

// ---- test/tb.sv ----
`timescale 1ns/100ps
module tb;
  import sensor_ctrl_pkg::*;
  localparam logic [7:0] ID = 8'hC3; // identity value, arbitrary
  localparam int TPS = 2000; // shortened second
  localparam int HZ [1:7] = '{1, 10, 25, 50, 75, 100, 200};
  logic clk_i, sys_rst_i, link_clk_i, acc_req_i, acc_we_i, i3c_mode_i;
  logic [6:0] acc_addr_i;
  logic [7:0] acc_wdata_i, acc_rdata_o, q, v, starts, s0;
  logic acc_busy_o, acc_done_o, conv_start_o, conv_done_i, i2c_enable_o, i3c_enable_o;
  logic spi_three_wire_o, sda_pullup_o, sdo_pullup_o, int_pulldown_o, int_pad_oe_o;
  logic lpf_enable_o, low_noise_o;
  logic [1:0] bw_sel_o;
  logic [23:0] press_raw_i;
  logic [15:0] temp_raw_i, gap;
  int err_total, compares;
  sensor_ctrl #(.DEVICE_ID(ID), .TICKS_PER_SEC(TPS)) u_sensor_ctrl (.*);
  frontend_model u_frontend_model (.clk_i(clk_i), .start_i(conv_start_o),
    .done_o(conv_done_i), .press_o(press_raw_i), .temp_o(temp_raw_i));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    link_clk_i = 1'b0;
    #3;
    forever #40 link_clk_i = ~link_clk_i;
  end
  // count conversion starts
  always @(posedge clk_i) begin
    if (conv_start_o === 1'b1) starts <= starts + 8'h01;
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one register access, request held one link clock, then wait for done
  task acc(input logic we, input logic [6:0] a, input logic [7:0] d);
    int n;
    @(posedge link_clk_i); #1;
    acc_req_i = 1'b1;
    acc_we_i = we;
    acc_addr_i = a;
    acc_wdata_i = d;
    @(posedge link_clk_i); #1;
    acc_req_i = 1'b0;
    acc_addr_i = ~a;
    acc_wdata_i = ~d;
    n = 0;
    while (acc_done_o !== 1'b1 && n < 20) begin
      @(posedge link_clk_i); #1;
      n++;
    end
    if (n == 20) err_total++;
    q = acc_rdata_o;
  endtask : acc
  task rd(input logic [6:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk({8'h00, q}, {8'h00, e});
  endtask : rd
  // pin levels a few clocks after a register change
  task pins(input logic [7:0] e1, input logic [2:0] e2);
    repeat (4) @(posedge clk_i); #1;
    chk({8'h00, i2c_enable_o, i3c_enable_o, spi_three_wire_o, sda_pullup_o, sdo_pullup_o,
      int_pulldown_o, int_pad_oe_o, lpf_enable_o}, {8'h00, e1});
    chk({13'h0000, bw_sel_o, low_noise_o}, {13'h0000, e2});
  endtask : pins
  // clocks from one start to the next
  task nxt_start();
    int n;
    n = 0;
    do begin
      @(posedge clk_i); #1;
      n++;
    end while (conv_start_o !== 1'b1 && n < 5000);
    gap = 16'(n);
  endtask : nxt_start
  task test_done();
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done
  initial begin
    #500000;
    err_total++;
    test_done();
  end
  initial begin
    {sys_rst_i, acc_req_i, acc_we_i, i3c_mode_i, acc_addr_i, acc_wdata_i} = 19'h40000;
    {err_total, compares, starts} = 0;
    repeat (6) @(posedge clk_i); #1;
    sys_rst_i = 1'b0;
    repeat (6) @(posedge link_clk_i);
    pins(8'hC6, 3'h0);
    rd(ADDR_ACQ_CTRL, 8'h00);
    rd(ADDR_IF_CTRL, 8'h00);
    acc(1'b1, ADDR_IDENT, 8'hFF);
    rd(ADDR_IDENT, ID);
    acc(1'b1, 7'h05, 8'hFF);
    rd(7'h05, 8'h00);
    i3c_mode_i = 1'b1;
    acc(1'b1, ADDR_IF_CTRL, 8'hFF);
    rd(ADDR_IF_CTRL, IF_CTRL_MASK);
    pins(8'h1A, 3'h0);
    acc(1'b1, ADDR_IF_CTRL, 8'h00);
    pins(8'hC4, 3'h0);
    i3c_mode_i = 1'b0;
    acc(1'b1, ADDR_ACQ_CTRL, 8'h81);
    rd(ADDR_ACQ_CTRL, 8'h01);
    pins(8'hE6, 3'h0);
    acc(1'b1, ADDR_ACQ_CTRL, 8'h00);
    acc(1'b1, ADDR_ACQ_CTRL2, 8'h01);
    repeat (40) @(posedge clk_i);
    rd(ADDR_ACQ_CTRL2, 8'h00);
    rd(ADDR_TEMP_L, 8'hFE);
    rd(ADDR_TEMP_H, 8'h01);
    rd(ADDR_PRESS_XL, 8'h01);
    rd(ADDR_PRESS_H, 8'h01);
    repeat (100) @(posedge clk_i); #1;
    chk({8'h00, starts}, 16'h0001);
    acc(1'b1, ADDR_ACQ_CTRL2, 8'h02);
    for (int c = 1; c < 8; c++) begin
      acc(1'b1, ADDR_ACQ_CTRL, {1'b0, 3'(c), 4'hC});
      nxt_start();
      nxt_start();
      nxt_start();
      chk(gap, 16'(TPS / HZ[c]));
      chk({13'h0000, bw_sel_o, low_noise_o}, {13'h0000, BW_DIV20, c < 6});
      chk({15'h0000, lpf_enable_o}, 16'h0001);
    end
    acc(1'b1, ADDR_ACQ_CTRL, 8'h32);
    pins(8'hC6, 3'h1);
    acc(1'b1, ADDR_ACQ_CTRL, 8'h72);
    repeat (30) @(posedge clk_i);
    acc(1'b0, ADDR_PRESS_XL, 8'h00);
    v = q;
    repeat (50) @(posedge clk_i);
    rd(ADDR_PRESS_L, v);
    rd(ADDR_TEMP_L, ~v);
    rd(ADDR_TEMP_H, v);
    rd(ADDR_PRESS_H, v);
    repeat (30) @(posedge clk_i);
    acc(1'b0, ADDR_PRESS_XL, 8'h00);
    chk({15'h0000, q !== v}, 16'h0001);
    acc(1'b1, ADDR_ACQ_CTRL2, 8'h01);
    rd(ADDR_ACQ_CTRL2, 8'h00);
    acc(1'b1, ADDR_ACQ_CTRL, 8'h00);
    repeat (20) @(posedge clk_i); #1;
    s0 = starts;
    repeat (100) @(posedge clk_i); #1;
    chk({8'h00, starts}, {8'h00, s0});
    rd(ADDR_IF_CTRL, 8'h00);
    test_done();
  end
endmodule : tb
bind sensor_ctrl sensor_ctrl_props u_sensor_ctrl_props (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .link_clk_i(link_clk_i), .acc_req_i(acc_req_i), .acc_busy_o(acc_busy_o),
  .acc_done_o(acc_done_o), .conv_start_o(conv_start_o), .conv_done_i(conv_done_i),
  .i3c_mode_i(i3c_mode_i), .i2c_enable_o(i2c_enable_o), .i3c_enable_o(i3c_enable_o),
  .int_pulldown_o(int_pulldown_o), .sda_pullup_o(sda_pullup_o),
  .int_pad_oe_o(int_pad_oe_o), .bw_sel_o(bw_sel_o));
